// *** rtl/gpio_port_pkg.sv ***
/*
  Constants, types and register map of the general purpose I/O port block.
  Assumes a 32-bit classic Wishbone bus with 8-bit registers in the low byte.
*/
package gpio_port_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FIRST_PORT_OFS = 8'h00;
  localparam logic [7:0] FIRST_DIR_OFS = 8'h04;
  localparam logic [7:0] FIRST_LAT_OFS = 8'h08;
  localparam logic [7:0] CONV_CTRL_OFS = 8'h0C;
  localparam logic [7:0] SEG_EN_ONE_OFS = 8'h10;
  localparam logic [7:0] SEG_EN_TWO_OFS = 8'h14;
  localparam logic [7:0] INT_CTRL_TWO_OFS = 8'h18;
  localparam logic [7:0] SEVENTH_PORT_OFS = 8'h1C;
  localparam logic [7:0] SEVENTH_DIR_OFS = 8'h20;
  localparam logic [7:0] SEVENTH_LAT_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [7:0] SEG_EN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCFG_LSB = 0;
  localparam int CONV_CTRL_MSB = 5;
  localparam int SECOND_PU_BIT = 7;
  localparam int FOURTH_PU_BIT = 5;
  localparam int FIFTH_PU_BIT = 6;
  localparam int NINTH_PU_BIT = 7;
  localparam int SEVENTH_PINS = 5;
  localparam int OD_LSB = 5;
  localparam int TIMER_PIN = 4;
  localparam int OSC_LO_PIN = 6;
  localparam int SEG14_BIT = 6;
  localparam int SEG15_BIT = 7;
  localparam int SEG18_BIT = 2;
  localparam logic [3:0] PCFG_ALL_ANALOG_MAX = 4'h6;
  localparam logic [7:0] ANALOG_PINS = 8'h2F;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic [2:0] seg;
    logic timer_clk;
  } periph_t;

endpackage

// *** rtl/gpio_port.sv ***
/*
  General purpose I/O port block: first port with analog, oscillator and
  display segment sharing, pull-up and open-drain control bits, and a
  five-pin seventh port. Assumes a classic Wishbone master on clk_sys_i
  and pad cells that turn out/oe/pull-up enables into pin levels.
*/
// How it works
// - Pin-read register returns synchronised pin levels, not the latch.
// - Writing the pin-read address stores into the output latch.
// - Direction bit one turns the pin driver off, pin is input.
// - Direction bit zero drives the pin from its latch bit.
// - Latch register reads back the latched value for read-modify-write.
// - Each port has direction, pin-read and latch registers.
// - An enabled segment or external oscillator takes the pin away from I/O; analog pins only read zero.
// - Second, fourth, fifth and ninth ports get weak pull-up enables.
// - Pull-up bits: interrupt control two bit 7, seventh port bits 7:5.
// - Open-drain bits for serial, SPI, capture outputs in seventh regs.
// - First port is eight bits, bidirectional, own direction and latch.
// - Bit 4 shares timer clock and segment; 5,3:0 share analog.
// - Port configuration field picks analog or digital for those pins.
// - Reset makes 5,3:0 analog reading zero, bit 4 digital input.
// - External oscillator owns bits 6,7; direction and latch read zero.
// - Internal oscillator select frees bits 6,7 as digital I/O.
// - Bits 1, 4, 5 are I/O only while segment enables are clear.
`timescale 1ns/1ps
module gpio_port
  import gpio_port_pkg::*;
(
  input wire logic clk_sys_i, // System clock, 25 MHz
  input wire logic rst_b_i, // Async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [7:0] first_port_in_i, // First port pin levels
  output pin_drive_t first_port_o, // First port drive and enable
  input wire logic [4:0] seventh_port_in_i, // Seventh port pin levels
  output logic [4:0] seventh_port_out_o, // Seventh port drive value
  output logic [4:0] seventh_port_oe_o, // Seventh port drive enable
  input wire logic oscillator_select_cfg_i, // 1: external oscillator mode
  input wire logic [2:0] seg_drive_i, // Segment 18,14,15 drive levels
  output periph_t periph_o, // Segment enables, timer clock
  output logic [3:0] pullup_en_o, // Pull-ups: ninth,fifth,fourth,second
  output logic [5:0] open_drain_o // Open-drain enables per module
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] first_port_direction_reg;
  logic [7:0] output_latch_reg;
  logic [7:0] converter_control_one_reg;
  logic [7:0] segment_enable_one_reg;
  logic [7:0] segment_enable_two_reg;
  logic [7:0] interrupt_control_two_reg;
  logic [7:0] seventh_port_ctrl_reg;
  logic [7:0] seventh_port_direction_reg;
  logic [7:0] seventh_port_latch_reg;
  logic [7:0] first_sync1_reg;
  logic [7:0] first_sync2_reg;
  logic [4:0] seventh_sync1_reg;
  logic [4:0] seventh_sync2_reg;
  logic osc_sync1_reg;
  logic osc_ext_reg;

  logic bus_req;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] analog_mask;
  logic [7:0] seg_mask;
  logic [7:0] osc_mask;
  logic [7:0] first_read;
  logic [7:0] dir_read;
  logic [7:0] lat_read;
  logic [7:0] rd_byte;
  pin_drive_t first_next;

  // Analog pins in mask form; zero means all digital
  function automatic logic [7:0] analog_of(input logic [3:0] pcfg);
    analog_of = (pcfg <= PCFG_ALL_ANALOG_MAX) ? ANALOG_PINS : 8'h00;
  endfunction

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_en && (wb_adr_i == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ack is withheld for the cycle after it is given, so a held request
  // is taken exactly once.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      first_sync1_reg <= 8'h00;
      first_sync2_reg <= 8'h00;
      seventh_sync1_reg <= 5'h00;
      seventh_sync2_reg <= 5'h00;
      osc_sync1_reg <= 1'b0;
      osc_ext_reg <= 1'b0;
    end
    else
    begin
      first_sync1_reg <= first_port_in_i;
      first_sync2_reg <= first_sync1_reg;
      seventh_sync1_reg <= seventh_port_in_i;
      seventh_sync2_reg <= seventh_sync1_reg;
      osc_sync1_reg <= oscillator_select_cfg_i;
      osc_ext_reg <= osc_sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // First port registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      first_port_direction_reg <= DIR_RST;
    else if (hit(FIRST_DIR_OFS))
      first_port_direction_reg <= wr_byte;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      output_latch_reg <= LAT_RST;
    else if (hit(FIRST_LAT_OFS) || hit(FIRST_PORT_OFS))
      output_latch_reg <= wr_byte;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      converter_control_one_reg <= CONV_CTRL_RST;
    else if (hit(CONV_CTRL_OFS))
      converter_control_one_reg <= {2'b00, wr_byte[CONV_CTRL_MSB:0]};
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      segment_enable_one_reg <= SEG_EN_RST;
      segment_enable_two_reg <= SEG_EN_RST;
    end
    else
    begin
      if (hit(SEG_EN_ONE_OFS))
        segment_enable_one_reg <= wr_byte;
      if (hit(SEG_EN_TWO_OFS))
        segment_enable_two_reg <= wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // Pull-up and open-drain control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      interrupt_control_two_reg <= CTRL_RST;
      seventh_port_ctrl_reg <= CTRL_RST;
    end
    else
    begin
      if (hit(INT_CTRL_TWO_OFS))
        interrupt_control_two_reg <= wr_byte;
      if (hit(SEVENTH_PORT_OFS))
        seventh_port_ctrl_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seventh_port_direction_reg <= DIR_RST;
      seventh_port_latch_reg <= LAT_RST;
    end
    else
    begin
      if (hit(SEVENTH_DIR_OFS))
        seventh_port_direction_reg <= wr_byte;
      if (hit(SEVENTH_LAT_OFS) || hit(SEVENTH_PORT_OFS))
        seventh_port_latch_reg[SEVENTH_PINS-1:0] <= wr_byte[SEVENTH_PINS-1:0];
      if (hit(SEVENTH_LAT_OFS))
        seventh_port_latch_reg[7:SEVENTH_PINS] <= wr_byte[7:SEVENTH_PINS];
    end
  end

  // ----------------------------------------------------------------
  // Pin sharing
  // ----------------------------------------------------------------
  assign analog_mask = analog_of(converter_control_one_reg[PCFG_LSB+:4]);
  assign seg_mask = {2'b00, segment_enable_one_reg[SEG15_BIT],
                     segment_enable_one_reg[SEG14_BIT], 2'b00,
                     segment_enable_two_reg[SEG18_BIT], 1'b0};
  assign osc_mask = osc_ext_reg ? 8'hC0 : 8'h00;

  // Analog and oscillator pins read zero; segment pins read zero as well
  assign first_read = first_sync2_reg & ~analog_mask & ~osc_mask & ~seg_mask;
  assign dir_read = first_port_direction_reg & ~osc_mask;
  assign lat_read = output_latch_reg & ~osc_mask;

  always_comb
  begin
    // Driver follows direction even on analog pins; software keeps it set
    first_next.oe = ~first_port_direction_reg & ~osc_mask;
    first_next.out = output_latch_reg & ~osc_mask;
    // Enabled segment drivers override all other functions
    if (seg_mask[1])
    begin
      first_next.oe[1] = 1'b1;
      first_next.out[1] = seg_drive_i[2];
    end
    if (seg_mask[TIMER_PIN])
    begin
      first_next.oe[TIMER_PIN] = 1'b1;
      first_next.out[TIMER_PIN] = seg_drive_i[1];
    end
    if (seg_mask[5])
    begin
      first_next.oe[5] = 1'b1;
      first_next.out[5] = seg_drive_i[0];
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      first_port_o <= '0;
      seventh_port_out_o <= 5'h00;
      seventh_port_oe_o <= 5'h00;
      periph_o <= '0;
    end
    else
    begin
      first_port_o <= first_next;
      seventh_port_out_o <= seventh_port_latch_reg[SEVENTH_PINS-1:0];
      seventh_port_oe_o <= ~seventh_port_direction_reg[SEVENTH_PINS-1:0];
      periph_o.seg <= {seg_mask[1], seg_mask[TIMER_PIN], seg_mask[5]};
      periph_o.timer_clk <= first_sync2_reg[TIMER_PIN];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pullup_en_o <= 4'h0;
      open_drain_o <= 6'h00;
    end
    else
    begin
      pullup_en_o <= {seventh_port_ctrl_reg[NINTH_PU_BIT],
                      seventh_port_ctrl_reg[FIFTH_PU_BIT],
                      seventh_port_ctrl_reg[FOURTH_PU_BIT],
                      interrupt_control_two_reg[SECOND_PU_BIT]};
      open_drain_o <= {seventh_port_latch_reg[7:OD_LSB],
                       seventh_port_direction_reg[7:OD_LSB]};
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (wb_adr_i)
      FIRST_PORT_OFS: rd_byte = first_read;
      FIRST_DIR_OFS: rd_byte = dir_read;
      FIRST_LAT_OFS: rd_byte = lat_read;
      CONV_CTRL_OFS: rd_byte = converter_control_one_reg;
      SEG_EN_ONE_OFS: rd_byte = segment_enable_one_reg;
      SEG_EN_TWO_OFS: rd_byte = segment_enable_two_reg;
      INT_CTRL_TWO_OFS: rd_byte = interrupt_control_two_reg;
      SEVENTH_PORT_OFS: rd_byte = {seventh_port_ctrl_reg[7:SEVENTH_PINS],
                                   seventh_sync2_reg};
      SEVENTH_DIR_OFS: rd_byte = seventh_port_direction_reg;
      SEVENTH_LAT_OFS: rd_byte = seventh_port_latch_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req && !wb_we_i)
      wb_dat_o <= {24'h00_0000, rd_byte};
  end

endmodule

// *** testbench/gpio_port_asserts.sv ***
/* Concurrent checks on the I/O port block ports.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module gpio_port_asserts
  import gpio_port_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_b_i, // Reset, low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [3:0] wb_sel_i, // Selects
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic [7:0] first_port_in_i, // Pins
  input wire pin_drive_t first_port_o, // Drive
  input wire logic oscillator_select_cfg_i, // Strap
  input wire periph_t periph_o, // Periph
  input wire logic [3:0] pullup_en_o, // Pull-ups
  input wire logic [5:0] open_drain_o // Open-drain
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  logic take;
  logic wr;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i && wb_sel_i[0];
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("ack late");
  a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'hFC |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Register written at the taking edge, registered outputs one edge later
  a_dir_sets_oe: assert property (wr && wb_adr_i == FIRST_DIR_OFS |-> ##2
    (first_port_o.oe & 8'h0D) == (~$past(wb_dat_i[7:0], 2) & 8'h0D)) else $error("oe vs dir");
  a_port_to_latch: assert property (wr && wb_adr_i == FIRST_PORT_OFS |-> ##2
    ((first_port_o.out ^ $past(wb_dat_i[7:0], 2)) & first_port_o.oe & 8'h0D) == 8'h00)
    else $error("port write not driven");
  a_reset_input: assert property ($rose(rst_b_i) |->
    first_port_o.oe == 8'h00 ##1 first_port_o.oe == 8'h00) else $error("driving after reset");
  // Guard keeps attempts out whose synchroniser history reaches into reset
  a_osc_owns: assert property (oscillator_select_cfg_i [*4] ##0 $past(rst_b_i, 3) |->
    first_port_o.oe[7:6] == 2'b00) else $error("oscillator pins driven");
  a_timer_follows: assert property ($stable(first_port_in_i[4]) [*4] ##0 $past(rst_b_i, 3) |->
    periph_o.timer_clk == first_port_in_i[4]) else $error("timer input stale");
  a_pullup_second: assert property (wr && wb_adr_i == INT_CTRL_TWO_OFS |-> ##2
    pullup_en_o[0] == $past(wb_dat_i[7], 2)) else $error("pull-up bit");
  a_od_dir_bits: assert property (wr && wb_adr_i == SEVENTH_DIR_OFS |-> ##2
    open_drain_o[2:0] == $past(wb_dat_i[7:5], 2)) else $error("open-drain bits");
  c_dir_write: cover property (wr && wb_adr_i == FIRST_DIR_OFS);
  c_pin_read: cover property (take && !wb_we_i && wb_adr_i == FIRST_PORT_OFS);
  c_osc_mode: cover property (oscillator_select_cfg_i [*4]);
endmodule
bind gpio_port gpio_port_asserts chk (.clk_sys_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .first_port_in_i, .first_port_o,
  .oscillator_select_cfg_i, .periph_o, .pullup_en_o, .open_drain_o);

// *** testbench/pin_partner.sv ***
/* Pads and outside circuits of the first and seventh ports.
   Assumes the bench sets what the outside drives on undriven pins. */
`timescale 1ns/1ps
module pin_partner
  import gpio_port_pkg::*;
(
  input wire pin_drive_t drive_i, // Block drive
  input wire logic [7:0] ext_i, // Outside level
  input wire logic [4:0] out7_i, // Seventh drive
  input wire logic [4:0] oe7_i, // Seventh enable
  input wire logic [4:0] ext7_i, // Outside level
  output logic [7:0] pins_o, // First pins
  output logic [4:0] pins7_o // Seventh pins
);
  // An enabled driver wins; a released pin shows the outside level
  assign pins_o = (drive_i.out & drive_i.oe) | (ext_i & ~drive_i.oe);
  assign pins7_o = (out7_i & oe7_i) | (ext7_i & ~oe7_i);
endmodule

// *** testbench/gpio_port_tb.sv ***
/* Self-checking bench for the I/O port block over Wishbone.
   Assumes the partner resolves pin levels from drive and outside. */
`timescale 1ns/1ps
module gpio_port_tb;
  import gpio_port_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] pins;
  logic [7:0] ext = 8'hFF;
  logic [4:0] pins7;
  logic [4:0] out7;
  logic [4:0] oe7;
  logic osc = 1'b0;
  logic [2:0] segd = 3'b101;
  logic [7:0] last;
  pin_drive_t drv;
  periph_t per;
  logic [3:0] pu;
  logic [5:0] od;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  gpio_port uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .first_port_in_i(pins), .first_port_o(drv), .seventh_port_in_i(pins7),
    .seventh_port_out_o(out7), .seventh_port_oe_o(oe7), .oscillator_select_cfg_i(osc),
    .seg_drive_i(segd), .periph_o(per), .pullup_en_o(pu), .open_drain_o(od));
  pin_partner far (.drive_i(drv), .ext_i(ext), .out7_i(out7), .oe7_i(oe7),
    .ext7_i(5'h0A), .pins_o(pins), .pins7_o(pins7));
  initial
  begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Cuts a hung handshake short
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= {3'h0, s};
    do
      @(posedge clk_sys_i);
    while (ack !== 1'b1);
    last = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 1'b1);
    check(last, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys_i);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(FIRST_DIR_OFS, DIR_RST);
    rd(FIRST_LAT_OFS, LAT_RST);
    rd(FIRST_PORT_OFS, 8'hD0);
    check(drv.oe, 8'h00);
    $display("done: reset");
    wr(CONV_CTRL_OFS, 8'h0F);
    wr(FIRST_PORT_OFS, 8'hA5);
    rd(FIRST_LAT_OFS, 8'hA5);
    wr(FIRST_DIR_OFS, 8'h00);
    settle();
    check(drv.oe, 8'hFF);
    check(drv.out, 8'hA5);
    rd(FIRST_PORT_OFS, 8'hA5);
    wr(FIRST_DIR_OFS, 8'hFF);
    ext <= 8'h5A;
    settle();
    rd(FIRST_PORT_OFS, 8'h5A);
    wr(FIRST_LAT_OFS, 8'hE5);
    rd(FIRST_LAT_OFS, 8'hE5);
    wr(CONV_CTRL_OFS, 8'h06);
    rd(FIRST_PORT_OFS, 8'h50);
    wr(CONV_CTRL_OFS, 8'h07);
    rd(FIRST_PORT_OFS, 8'h5A);
    $display("done: latch and pins");
    wr(SEG_EN_ONE_OFS, 8'hC0);
    wr(SEG_EN_TWO_OFS, 8'h04);
    settle();
    check({5'h0, per.seg}, 8'h07);
    check(drv.oe & 8'h32, 8'h32);
    check(drv.out & 8'h32, 8'h22);
    rd(FIRST_PORT_OFS, 8'h48);
    wr(SEG_EN_ONE_OFS, 8'h00);
    wr(SEG_EN_TWO_OFS, 8'h00);
    $display("done: segments");
    wr(FIRST_DIR_OFS, 8'h3F);
    wr(FIRST_LAT_OFS, 8'hC0);
    osc <= 1'b1;
    settle();
    check(drv.oe & 8'hC0, 8'h00);
    rd(FIRST_DIR_OFS, 8'h3F);
    rd(FIRST_LAT_OFS, 8'h00);
    rd(FIRST_PORT_OFS, 8'h1A);
    osc <= 1'b0;
    settle();
    check(drv.oe & 8'hC0, 8'hC0);
    rd(FIRST_LAT_OFS, 8'hC0);
    wr(FIRST_DIR_OFS, 8'hFF);
    $display("done: oscillator");
    wr(INT_CTRL_TWO_OFS, 8'h80);
    wr(SEVENTH_LAT_OFS, 8'h60);
    wr(SEVENTH_PORT_OFS, 8'hF5);
    wr(SEVENTH_DIR_OFS, 8'hA0);
    settle();
    check({4'h0, pu}, 8'h0F);
    check({2'h0, od}, 8'h1D);
    check({3'h0, out7}, 8'h15);
    rd(SEVENTH_LAT_OFS, 8'h75);
    rd(SEVENTH_PORT_OFS, 8'hF5);
    $display("done: seventh port");
    rd(8'hFC, 8'h00);
    wb(1'b1, FIRST_DIR_OFS, 8'h00, 1'b0);
    rd(FIRST_DIR_OFS, 8'hFF);
    ext <= 8'h10;
    settle();
    check({7'h0, per.timer_clk}, 8'h01);
    rd(FIRST_PORT_OFS, 8'h10);
    ext <= 8'h00;
    settle();
    check({7'h0, per.timer_clk}, 8'h00);
    $display("done: bus and timer");
    wrap_up();
  end
endmodule
